// *** dv/csh_ctrl_assertions.sv ***
/* Checker on the csh_ctrl ports.
   Bound to every csh_ctrl instance. */
`timescale 1ns/1ps
module csh_ctrl_assertions (input wire logic ref_clk_i, rst_n_i, config_request_line_n_i,
  config_status_line_i, config_status_line_o, config_status_line_oe_o, config_done_line_i,
  config_done_line_o, config_done_line_oe_o, cfg_data_last_i, cfg_data_err_i,
  cfg_active_o, user_mode_o, io_tristate_o, config_error_o);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_last;
    cfg_active_o && cfg_data_last_i && !cfg_data_err_i && config_request_line_n_i &&
    config_status_line_i;
  endsequence
  a_por_hold: assert property ($rose(rst_n_i) |-> config_status_line_oe_o[*7])
    else $error("por");
  a_ext_status: assert property (cfg_active_o && !config_status_line_i &&
    !config_status_line_oe_o && config_request_line_n_i |=> config_error_o) else $error("ext");
  a_user_holds: assert property (user_mode_o && config_request_line_n_i |=> user_mode_o)
    else $error("user");
  a_done_cfg: assert property (cfg_active_o |-> config_done_line_oe_o)
    else $error("done");
  a_done_rel: assert property (s_last |=> !config_done_line_oe_o)
    else $error("rel");
  a_user_done: assert property ($rose(user_mode_o) |-> $past(config_done_line_i))
    else $error("init");
  a_req_reset: assert property (user_mode_o && !config_request_line_n_i |=>
    !user_mode_o && io_tristate_o) else $error("req");
  a_low_only: assert property (!config_status_line_o && !config_done_line_o)
    else $error("high");
endmodule // csh_ctrl_assertions
bind csh_ctrl csh_ctrl_assertions u_chk (.*);

// *** dv/csh_host_model.sv ***
/* Far side: pull-ups and wired-AND on the status and done lines.
   Assumes pull requests come from the bench. */
`timescale 1ns/1ps
module csh_host_model (input wire logic st_oe_i, dn_oe_i, pull_st_i, pull_dn_i,
  output logic status_o, done_o);
  assign status_o = !(st_oe_i || pull_st_i);
  assign done_o = !(dn_oe_i || pull_dn_i);
endmodule // csh_host_model

// *** dv/test_config_status_handshake.sv ***
/* Self-checking bench for the status handshake block.
   Assumes the host model and the bound checker. */
`timescale 1ns/1ps
module test_config_status_handshake;
  logic clk = 0, rst_n = 0, req_n = 0, last = 0, err = 0, p_st = 0, p_dn = 0;
  logic st_i, st_o, st_oe, dn_i, dn_o, dn_oe, act, usr, tri_s, cerr;
  logic [31:0] rs = 32'h33;
  logic [11:0] q[$];
  int n_errors = 0, checks = 0, cyc = 0;
  wire [5:0] obs = {st_oe, dn_oe, act, usr, tri_s, cerr};
  event ev;
  initial forever #5 clk = ~clk;
  csh_ctrl #(.POR_CYCLES(8)) u_dut (.ref_clk_i(clk), .rst_n_i(rst_n),
    .config_request_line_n_i(req_n), .config_status_line_i(st_i), .config_status_line_o(st_o),
    .config_status_line_oe_o(st_oe), .config_done_line_i(dn_i), .config_done_line_o(dn_o),
    .config_done_line_oe_o(dn_oe), .cfg_data_last_i(last), .cfg_data_err_i(err),
    .cfg_active_o(act), .user_mode_o(usr), .io_tristate_o(tri_s), .config_error_o(cerr));
  csh_host_model u_host (.st_oe_i(st_oe), .dn_oe_i(dn_oe), .pull_st_i(p_st), .pull_dn_i(p_dn),
    .status_o(st_i), .done_o(dn_i));
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] r;
    r = v ^ (v << 13);
    r = r ^ (r >> 17);
    xs = r ^ (r << 5);
  endfunction
  task automatic check(input logic [5:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch outputs exp %b seen %b", exp, seen);
    end
  endtask
  task automatic step(input int n, input logic [5:0] m, e);
    repeat (n) @(negedge clk);
    q.push_back({m, e});
    -> ev;
  endtask
  always @(ev) begin
    logic [11:0] t;
    t = q.pop_front();
    check(obs & t[11:6], t[5:0]);
  end
  task give_verdict;
    if (n_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1;
    req_n = 1;
    step(1, 6'h3F, 6'h32);
    step(11, 6'h3F, 6'h1A);
    rs = xs(rs);
    step(int'(rs[1:0]) + 1, 6'h3F, 6'h1A);
    last = 1;
    step(1, 6'h3F, 6'h02);
    last = 0;
    step(20, 6'h3F, 6'h04);
    repeat (8) begin
      rs = xs(rs);
      {p_st, p_dn} = rs[1:0];
      @(negedge clk);
    end
    {p_st, p_dn} = 2'h0;
    step(1, 6'h3F, 6'h04);
    req_n = 0;
    step(2, 6'h3F, 6'h12);
    req_n = 1;
    step(3, 6'h3F, 6'h1A);
    err = 1;
    step(1, 6'h2D, 6'h21);
    err = 0;
    step(12, 6'h3F, 6'h1A);
    p_st = 1;
    step(1, 6'h2D, 6'h21);
    p_st = 0;
    step(12, 6'h3F, 6'h1A);
    give_verdict();
  end
endmodule // test_config_status_handshake

// *** rtl/csh_ctrl.sv ***
/*
  Configuration controller status pin handshake: drives and watches the open-drain
  status and done lines and reacts to the configuration request line.
  Assumes all inputs synchronous to ref_clk_i, open-drain lines resolved outside.
*/
// Functional notes
// - Hold status low until power-on interval ends.
// - Pull status low on configuration data error.
// - External status low in config/init means error.
// - Ignore status line transitions in user mode.
// - After status release, accept fresh configuration.
// - Hold done low before and during configuration.
// - Release done after clean data, init start.
// - Enter user mode only after done reads high.
// - External done low ignored after initialization.
// - Request low in user mode resets; high reconfigures.
`timescale 1ns/1ps
`include "csh_defs.svh"
module csh_ctrl
  import csh_pkg::*;
#(
  parameter int unsigned POR_CYCLES  = `CSH_POR_CYCLES,
  parameter int unsigned INIT_CYCLES = `CSH_INIT_CYCLES,
  parameter int unsigned ERR_HOLD    = `CSH_ERR_HOLD_CYCLES
) (
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  input  wire logic config_request_line_n_i,
  input  wire logic config_status_line_i,
  output logic      config_status_line_o,
  output logic      config_status_line_oe_o,
  input  wire logic config_done_line_i,
  output logic      config_done_line_o,
  output logic      config_done_line_oe_o,
  input  wire logic cfg_data_last_i,
  input  wire logic cfg_data_err_i,
  output logic      cfg_active_o,
  output logic      user_mode_o,
  output logic      io_tristate_o,
  output logic      config_error_o
);
  localparam int unsigned MAX_A   = (POR_CYCLES > INIT_CYCLES) ? POR_CYCLES : INIT_CYCLES;
  localparam int unsigned MAX_CNT = (MAX_A > ERR_HOLD) ? MAX_A : ERR_HOLD;
  localparam int          CW      = (MAX_CNT > 2) ? $clog2(MAX_CNT + 1) : 2;

  csh_state_t      state_q;
  csh_state_t      state_d;
  logic [CW-1:0]   cnt_q;
  logic            cnt_done;
  logic            data_done_q;

  // True once all configuration data has arrived cleanly.
  function automatic logic is_loaded(input csh_state_t st);
    is_loaded = (st == CSH_ST_INIT) || (st == CSH_ST_USER);
  endfunction

  // True in the states that pull the status line low.
  function automatic logic holds_status(input csh_state_t st);
    holds_status = (st == CSH_ST_POR) || (st == CSH_ST_ERROR);
  endfunction

  always_comb begin
    if (state_q == CSH_ST_POR) begin
      cnt_done = (cnt_q >= CW'(POR_CYCLES - 1));
    end else if (state_q == CSH_ST_ERROR) begin
      cnt_done = (cnt_q >= CW'(ERR_HOLD - 1));
    end else begin
      cnt_done = (cnt_q >= CW'(INIT_CYCLES - 1));
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      CSH_ST_POR: begin
        if (cnt_done) begin
          state_d = CSH_ST_RESET;
        end
      end
      CSH_ST_RESET: begin
        if (config_request_line_n_i) begin
          state_d = CSH_ST_CONFIG;
        end
      end
      CSH_ST_CONFIG: begin
        if (!config_request_line_n_i) begin
          state_d = CSH_ST_RESET;
        end else if (cfg_data_err_i || !config_status_line_i) begin
          state_d = CSH_ST_ERROR;
        end else if (cfg_data_last_i) begin
          state_d = CSH_ST_INIT;
        end
      end
      CSH_ST_INIT: begin
        if (!config_request_line_n_i) begin
          state_d = CSH_ST_RESET;
        end else if (!config_status_line_i) begin
          state_d = CSH_ST_ERROR;
        end else if (config_done_line_i && cnt_done) begin
          state_d = CSH_ST_USER;
        end
      end
      CSH_ST_USER: begin
        if (!config_request_line_n_i) begin
          state_d = CSH_ST_RESET;
        end
      end
      CSH_ST_ERROR: begin
        if (!config_request_line_n_i) begin
          state_d = CSH_ST_RESET;
        end else if (cnt_done) begin
          state_d = CSH_ST_CONFIG;
        end
      end
      default: begin
        state_d = CSH_ST_POR;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= CSH_ST_POR;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else if (state_d != state_q) begin
      cnt_q <= '0;
    end else if (!cnt_done) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_done_q <= 1'b0;
    end else begin
      data_done_q <= is_loaded(state_d);
    end
  end

  // The status pin is only ever pulled low.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      config_status_line_o <= 1'b0;
    end else begin
      config_status_line_o <= 1'b0;
    end
  end

  // Status is pulled low during power-on and in the error state.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      config_status_line_oe_o <= 1'b1;
    end else begin
      config_status_line_oe_o <= holds_status(state_d);
    end
  end

  // The done pin is only ever pulled low.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      config_done_line_o <= 1'b0;
    end else begin
      config_done_line_o <= 1'b0;
    end
  end

  // Done is held low until the data is loaded.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      config_done_line_oe_o <= 1'b1;
    end else begin
      config_done_line_oe_o <= !is_loaded(state_d);
    end
  end

  // Flags the data loading phase.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_active_o <= 1'b0;
    end else begin
      cfg_active_o <= (state_d == CSH_ST_CONFIG);
    end
  end

  // Flags user mode once loading has finished.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      user_mode_o <= 1'b0;
    end else begin
      user_mode_o <= (state_d == CSH_ST_USER) && data_done_q;
    end
  end

  // Pins float everywhere but in user mode.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      io_tristate_o <= 1'b1;
    end else begin
      io_tristate_o <= (state_d != CSH_ST_USER);
    end
  end

  // Flags the error state.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      config_error_o <= 1'b0;
    end else begin
      config_error_o <= (state_d == CSH_ST_ERROR);
    end
  end
endmodule // csh_ctrl

// *** rtl/csh_defs.svh ***
/*
  Timing counts and clock rate for the configuration status handshake block.
  Assumes inclusion by bare name from the design module.
*/
`ifndef CSH_DEFS_SVH
`define CSH_DEFS_SVH
`define CSH_CLK_MHZ        100
`define CSH_POR_TIME_US    100
`define CSH_POR_CYCLES     (`CSH_POR_TIME_US * `CSH_CLK_MHZ)
`define CSH_INIT_CYCLES    16
`define CSH_ERR_HOLD_CYCLES 8
`endif

// *** rtl/csh_pkg.sv ***
/*
  Types shared by the configuration status handshake block.
  Assumes nothing from the defs header.
*/
package csh_pkg;
  typedef enum logic [2:0] {
    CSH_ST_POR    = 3'b000,
    CSH_ST_RESET  = 3'b001,
    CSH_ST_CONFIG = 3'b010,
    CSH_ST_INIT   = 3'b011,
    CSH_ST_USER   = 3'b100,
    CSH_ST_ERROR  = 3'b101
  } csh_state_t;
endpackage
